// ==== flash_rewrite_interrupt_suspend.sv ====
/*
 Flash rewrite sequencer: auto-erase and auto-program timing with
 erase-suspend, interrupt gating and forced abort with flash reset.
 Assumes the CPU core and interrupt controller run on core_clk and
 drive all inputs synchronously; commands only arrive while idle.
*/
`timescale 1ns/1ps
module flash_rewrite_interrupt_suspend
	import flash_rewrite_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Command start
	input wire logic start_erase,
	input wire logic start_program,
	input wire logic [BLK_W-1:0] cmd_block,
	input wire logic cmd_target,
	input wire logic cmd_mode,
	input wire logic cmd_suspend_enable,
	// Control bit writes
	input wire logic ctl_write,
	input wire logic ctl_erase_suspend_request,
	input wire logic ctl_suspend_on_interrupt_enable,
	// Interrupt side
	input wire logic maskable_request,
	input wire logic maskable_ack,
	input wire logic nonmaskable_ack,
	// Flash array access
	input wire logic [BLK_W-1:0] access_block,
	// Status and grants
	output logic erase_suspend_request,
	output logic suspend_on_interrupt_enable,
	output logic busy,
	output logic suspended,
	output logic op_done,
	output logic op_aborted,
	output logic flash_reset,
	output logic maskable_grant,
	output logic nonmaskable_grant,
	output logic access_allow
);
	seq_state_e state, next_state;
	logic [CNT_W-1:0] remain, next_remain;
	logic [CNT_W-1:0] wait_cnt, next_wait_cnt;
	logic [BLK_W-1:0] blk, next_blk;
	logic target, next_target;
	logic mode, next_mode;
	logic susp_en, next_susp_en;
	logic next_erase_suspend_request;
	logic next_suspend_on_interrupt_enable;
	logic next_busy, next_suspended, next_op_done, next_op_aborted;
	logic next_flash_reset, next_maskable_grant, next_nonmaskable_grant;
	logic next_access_allow;
	logic erasing, rom_ram, rom_flash_susp, auto_set, abort;

	always_comb begin
		next_state = state;
		next_remain = remain;
		next_wait_cnt = wait_cnt;
		next_blk = blk;
		next_target = target;
		next_mode = mode;
		next_susp_en = susp_en;
		next_op_done = 1'b0;
		next_op_aborted = 1'b0;
		erasing = (state == ST_ERASE);
		rom_ram = (target == TARGET_PROGRAM_ROM) &&
			(mode == MODE_RAM_EXECUTE);
		rom_flash_susp = (target == TARGET_PROGRAM_ROM) &&
			(mode == MODE_FLASH_EXECUTE) && susp_en;
		// Software write first, so the hardware set below wins
		next_erase_suspend_request = erase_suspend_request;
		next_suspend_on_interrupt_enable = suspend_on_interrupt_enable;
		if (ctl_write) begin
			next_erase_suspend_request = ctl_erase_suspend_request;
			next_suspend_on_interrupt_enable =
				ctl_suspend_on_interrupt_enable;
		end
		// Data flash: acknowledged interrupt with auto-suspend on
		auto_set = erasing && susp_en && suspend_on_interrupt_enable &&
			(target == TARGET_DATA_FLASH) &&
			(maskable_ack || nonmaskable_ack);
		// Flash-execute ROM: handler cannot run, so the request suspends
		if (erasing && rom_flash_susp && maskable_request) begin
			auto_set = 1'b1;
		end
		if (auto_set) begin
			next_erase_suspend_request = 1'b1;
		end
		abort = rom_ram && nonmaskable_ack &&
			(state != ST_IDLE) && (state != ST_RESTART);
		case (state)
			ST_IDLE: begin
				if (start_erase || start_program) begin
					next_blk = cmd_block;
					next_target = cmd_target;
					next_mode = cmd_mode;
					next_susp_en = cmd_suspend_enable;
					next_state = start_erase ? ST_ERASE : ST_PROGRAM;
					next_remain = start_erase ? ERASE_LOAD : PROG_LOAD;
				end
			end
			ST_ERASE, ST_PROGRAM: begin
				// Watchdog is not frozen here; software uses suspend
				// windows to refresh it
				if (remain == CNT_ONE) begin
					next_state = ST_IDLE;
					next_remain = CNT_ZERO;
					next_op_done = 1'b1;
				end else begin
					next_remain = remain - CNT_ONE;
				end
				if (erasing && susp_en && erase_suspend_request &&
						remain != CNT_ONE) begin
					next_state = ST_SUSPENDING;
					next_wait_cnt = LAT_LOAD;
				end
			end
			ST_SUSPENDING: begin
				// Erase keeps running until the latency has elapsed
				next_remain = (remain > CNT_ONE) ? remain - CNT_ONE : remain;
				if (wait_cnt == CNT_ONE) begin
					next_state = ST_SUSPENDED;
				end else begin
					next_wait_cnt = wait_cnt - CNT_ONE;
				end
			end
			ST_SUSPENDED: begin
				if (!erase_suspend_request) begin
					next_state = ST_ERASE;
				end
			end
			ST_RESTART: begin
				if (wait_cnt == CNT_ONE) begin
					next_state = ST_IDLE;
				end else begin
					next_wait_cnt = wait_cnt - CNT_ONE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		// Forced stop overrides any other progress
		if (abort) begin
			next_state = ST_RESTART;
			next_wait_cnt = RST_LOAD;
			next_remain = CNT_ZERO;
			next_op_aborted = 1'b1;
			// A cut operation never reports normal completion
			next_op_done = 1'b0;
			next_erase_suspend_request = 1'b0;
		end
		next_busy = (next_state != ST_IDLE);
		next_suspended = (next_state == ST_SUSPENDED);
		next_flash_reset = (next_state == ST_RESTART);
		// Non-maskable grant withheld only while the flash restarts
		next_nonmaskable_grant = (next_state != ST_RESTART);
		// Maskable gating depends on target, mode and suspend setting
		if (next_state == ST_IDLE || next_state == ST_RESTART) begin
			next_maskable_grant = (next_state == ST_IDLE);
		end else if (next_target == TARGET_DATA_FLASH) begin
			next_maskable_grant = 1'b1;
		end else if (next_mode == MODE_RAM_EXECUTE) begin
			// Vector must sit in RAM; that is the caller's duty
			next_maskable_grant = 1'b1;
		end else if (next_susp_en && (next_state == ST_ERASE ||
				next_state == ST_SUSPENDING || next_state == ST_SUSPENDED)) begin
			next_maskable_grant = (next_state == ST_SUSPENDED);
		end else begin
			next_maskable_grant = 1'b0;
		end
		// Only the interrupted block is fenced while suspended
		next_access_allow = (next_state == ST_IDLE) ||
			((next_state == ST_SUSPENDED) && (access_block != next_blk));
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			remain <= CNT_ZERO;
			wait_cnt <= CNT_ZERO;
			blk <= '0;
			target <= TARGET_DATA_FLASH;
			mode <= MODE_RAM_EXECUTE;
			susp_en <= 1'b0;
			erase_suspend_request <= 1'b0;
			suspend_on_interrupt_enable <= 1'b0;
			busy <= 1'b0;
			suspended <= 1'b0;
			op_done <= 1'b0;
			op_aborted <= 1'b0;
			flash_reset <= 1'b0;
			maskable_grant <= 1'b1;
			nonmaskable_grant <= 1'b1;
			access_allow <= 1'b1;
		end else begin
			state <= next_state;
			remain <= next_remain;
			wait_cnt <= next_wait_cnt;
			blk <= next_blk;
			target <= next_target;
			mode <= next_mode;
			susp_en <= next_susp_en;
			erase_suspend_request <= next_erase_suspend_request;
			suspend_on_interrupt_enable <= next_suspend_on_interrupt_enable;
			busy <= next_busy;
			suspended <= next_suspended;
			op_done <= next_op_done;
			op_aborted <= next_op_aborted;
			flash_reset <= next_flash_reset;
			maskable_grant <= next_maskable_grant;
			nonmaskable_grant <= next_nonmaskable_grant;
			access_allow <= next_access_allow;
		end
	end
endmodule

// ==== flash_rewrite_pkg.sv ====
/*
 Shared constants for the flash rewrite sequencer: state encoding,
 target and mode codes, and timing counts at the 40 MHz core clock.
 Assumes a single core clock domain shared with the CPU.
*/
package flash_rewrite_pkg;
	localparam int unsigned CLK_PERIOD_PS = 25000;
	// Suspend latency and restart period, in ns
	localparam int unsigned SUSPEND_LATENCY_NS = 5000;
	localparam int unsigned RESTART_PERIOD_NS = 10000;
	localparam int unsigned SUSPEND_LATENCY_CYC =
		(SUSPEND_LATENCY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned RESTART_PERIOD_CYC =
		(RESTART_PERIOD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// Modelled operation lengths in cycles
	localparam int unsigned ERASE_CYC = 1024;
	localparam int unsigned PROGRAM_CYC = 64;
	localparam int CNT_W = 11;
	localparam int BLK_W = 4;
	localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;
	localparam logic [CNT_W-1:0] CNT_ONE = 11'h001;
	localparam logic [CNT_W-1:0] LAT_LOAD = CNT_W'(SUSPEND_LATENCY_CYC);
	localparam logic [CNT_W-1:0] RST_LOAD = CNT_W'(RESTART_PERIOD_CYC);
	localparam logic [CNT_W-1:0] ERASE_LOAD = CNT_W'(ERASE_CYC);
	localparam logic [CNT_W-1:0] PROG_LOAD = CNT_W'(PROGRAM_CYC);
	// Target and mode codes
	localparam logic TARGET_DATA_FLASH = 1'b0;
	localparam logic TARGET_PROGRAM_ROM = 1'b1;
	localparam logic MODE_RAM_EXECUTE = 1'b0;
	localparam logic MODE_FLASH_EXECUTE = 1'b1;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_ERASE = 6'h02,
		ST_PROGRAM = 6'h04,
		ST_SUSPENDING = 6'h08,
		ST_SUSPENDED = 6'h10,
		ST_RESTART = 6'h20
	} seq_state_e;
endpackage

// ==== flash_rewrite_checker.sv ====
/* Port assertions for the sequencer, bound to its top; one clock. */
`timescale 1ns/1ps
module flash_rewrite_checker (
	// Clock, reset and control writes
	input wire logic core_clk, rst_n, ctl_write,
	input wire logic ctl_suspend_on_interrupt_enable,
	// Status
	input wire logic erase_suspend_request, suspend_on_interrupt_enable,
	input wire logic busy, suspended, op_done, op_aborted, flash_reset,
	input wire logic nonmaskable_grant
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// Resume shows one cycle after the request bit clears
	sequence s_resume;
		suspended && !erase_suspend_request;
	endsequence
	a_ctl_load: assert property (ctl_write |=>
		suspend_on_interrupt_enable == $past(ctl_suspend_on_interrupt_enable))
		else $error("enable bit not loaded");
	a_susp_delay: assert property ($rose(suspended) |->
		$past(erase_suspend_request, 201)) else $error("early suspend");
	a_resume_exit: assert property (s_resume |=> !suspended)
		else $error("suspend held after resume");
	a_susp_busy: assert property (suspended |-> busy && !flash_reset)
		else $error("suspended while idle");
	a_abort_state: assert property (op_aborted |-> flash_reset &&
		!nonmaskable_grant && !erase_suspend_request) else $error("bad abort");
	a_restart_len: assert property ($fell(flash_reset) |->
		$past(flash_reset, 400) && !$past(flash_reset, 401))
		else $error("restart period wrong");
	a_reset_hold: assert property (flash_reset |-> !nonmaskable_grant)
		else $error("grant during restart");
	a_done_pulse: assert property (op_done |-> !busy ##1 !op_done)
		else $error("done not a pulse");
endmodule
bind flash_rewrite_interrupt_suspend flash_rewrite_checker chk_i (.*);

// ==== cpu_model.sv ====
/* CPU model: acks a held maskable request once it is granted. */
`timescale 1ns/1ps
module cpu_model #(parameter int DELAY = 3) (
	// Clock, reset and interrupt side
	input wire logic core_clk, rst_n, maskable_request, maskable_grant,
	output logic maskable_ack
);
	int cnt;
	// Only granted requests are taken, so deferral is left to the device
	// Vector sits in RAM; no trap, break or debug events
	always @(posedge core_clk or negedge rst_n) begin
		cnt <= (!rst_n || !maskable_request || !maskable_grant) ? 0 : cnt + 1;
		maskable_ack <= rst_n && maskable_grant && cnt == DELAY;
	end
endmodule

// ==== test_flash_rewrite_interrupt_suspend.sv ====
/* Sequencer bench with CPU model; assumes a 40 MHz core clock. */
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
	miscompares++; $display("unexpected %0t %h %h", $time, g, e); end end
module test_flash_rewrite_interrupt_suspend
	import flash_rewrite_pkg::*;
;
	logic core_clk = 1'b0;
	logic rst_n, start_erase, start_program, cmd_target, cmd_mode, ctl_write;
	logic cmd_suspend_enable, ctl_erase_suspend_request, nonmaskable_ack;
	logic ctl_suspend_on_interrupt_enable, maskable_request, maskable_ack;
	logic erase_suspend_request, suspend_on_interrupt_enable, busy, suspended;
	logic op_done, op_aborted, flash_reset, maskable_grant, nonmaskable_grant;
	logic access_allow;
	logic redo = 1'b0;
	logic [BLK_W-1:0] cmd_block, access_block;
	int miscompares = 0, samples_checked = 0, act = 0;
	flash_rewrite_interrupt_suspend flash_rewrite_interrupt_suspend_i (.*);
	cpu_model cpu_model_i (.*);
	initial forever #12.5 core_clk = ~core_clk;
	// Bits: erase, program, target, mode, suspend, request, write, two bits
	task automatic drive(input logic [8:0] v);
		@(posedge core_clk);
		{start_erase, start_program, cmd_target, cmd_mode, cmd_suspend_enable,
			maskable_request, ctl_write, ctl_erase_suspend_request,
			ctl_suspend_on_interrupt_enable} <= v;
		// Block 0 holds the vectors, so it is never erased here
		if (!redo)
			cmd_block <= BLK_W'($urandom_range(15, 1));
		act = (v[8] | v[7]) ? 0 : act;
		@(posedge core_clk);
		{start_erase, start_program, ctl_write} <= 3'h0;
	endtask
	// Unsuspended cycles must add up to the operation length
	task automatic settle(input int lim, input logic on_done);
		for (int n = 0; n < lim; n++) begin
			@(negedge core_clk);
			if (on_done ? op_done : suspended)
				break;
			act += !suspended;
		end
	endtask
	task automatic end_of_test;
		$display("compared %0d, mismatched %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Work takes about 4000 cycles; far beyond that is a hang
	initial #(25 * 20000) begin
		miscompares++;
		end_of_test();
	end
	initial begin
		void'($urandom(14));
		{rst_n, start_erase, start_program, cmd_target, cmd_mode, ctl_write,
			cmd_suspend_enable, ctl_erase_suspend_request, nonmaskable_ack,
			ctl_suspend_on_interrupt_enable, maskable_request} <= 11'h000;
		{cmd_block, access_block} <= 8'h00;
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		@(negedge core_clk);
		`CHK({erase_suspend_request, suspend_on_interrupt_enable}, 2'h0)
		drive(9'h005);
		drive(9'h118);
		settle(2, 1'b0);
		`CHK(maskable_grant, 1'b1)
		settle(400, 1'b0);
		`CHK({erase_suspend_request, suspended}, 2'h3)
		for (int k = 0; k < 2; k++) begin
			@(posedge core_clk);
			access_block <= cmd_block + BLK_W'(k);
			repeat (2) @(negedge core_clk);
			`CHK(access_allow, k != 0)
		end
		drive(9'h004);
		settle(1200, 1'b1);
		`CHK(act, ERASE_CYC)
		// Flash-execute ROM program holds the request back
		drive(9'h0E8);
		settle(2, 1'b0);
		`CHK(maskable_grant, 1'b0)
		settle(300, 1'b1);
		`CHK(act, PROGRAM_CYC)
		@(negedge core_clk);
		`CHK(maskable_grant, 1'b1)
		// Flash-execute ROM erase: a pending request forces a suspend
		drive(9'h178);
		settle(2, 1'b0);
		`CHK(maskable_grant, 1'b0)
		settle(400, 1'b0);
		`CHK({suspended, maskable_grant}, 2'h3)
		drive(9'h004);
		settle(1200, 1'b1);
		`CHK(act, ERASE_CYC)
		drive(9'h140);
		repeat (5) @(posedge core_clk);
		nonmaskable_ack <= 1'b1;
		@(posedge core_clk);
		nonmaskable_ack <= 1'b0;
		@(negedge core_clk);
		`CHK({op_aborted, flash_reset, nonmaskable_grant}, 3'h6)
		repeat (410) @(negedge core_clk);
		`CHK({busy, nonmaskable_grant}, 2'h1)
		// Same block erased again; the handler sets the request itself
		redo = 1'b1;
		drive(9'h150);
		drive(9'h006);
		settle(400, 1'b0);
		`CHK({erase_suspend_request, suspended}, 2'h3)
		drive(9'h004);
		settle(1200, 1'b1);
		`CHK(op_done, 1'b1)
		end_of_test();
	end
endmodule
